// File: pkg/sstc_map.vh
`ifndef SSTC_MAP_VH
`define SSTC_MAP_VH

// Register byte offsets within the register frame.
`define SSTC_OFF_STRTAB_CFG     16'h8088
`define SSTC_OFF_CMDQ_BASE_LO   16'h8090
`define SSTC_OFF_CMDQ_BASE_HI   16'h8094

// Stream table configuration field positions.
`define SSTC_FMT_HI             17
`define SSTC_FMT_LO             16
`define SSTC_SPLIT_HI           10
`define SSTC_SPLIT_LO           6
`define SSTC_SIZE_HI            5
`define SSTC_SIZE_LO            0

// Table format and split encodings.
`define SSTC_FMT_LINEAR         2'h0
`define SSTC_FMT_TWO_LEVEL      2'h1
`define SSTC_SPLIT_6            5'h06
`define SSTC_SPLIT_8            5'h08
`define SSTC_SPLIT_10           5'h0A

// Command queue base field positions (64-bit view).
`define SSTC_RA_BIT             62
`define SSTC_ADDR_HI            51
`define SSTC_ADDR_LO            5
`define SSTC_QSIZE_HI           4
`define SSTC_QSIZE_LO           0
`define SSTC_QMIN_ALIGN_LOG2    6'h05

// Reset values used when the configuration is fixed.
`define SSTC_RST_STRTAB_CFG     32'h0001_0186
`define SSTC_RST_CMDQ_BASE      64'h4000_0000_0000_0008

`endif

// File: design/sstc_range_check.v
`timescale 1ns/1ps
`default_nettype none
`include "sstc_map.vh"

// Splits an incoming stream identifier into table indices and flags out-of-range ones.
module sstc_range_check
(
    // Effective configuration.
    input  wire        two_level_i,
    input  wire [5:0]  eff_size_i,
    input  wire [4:0]  eff_split_i,
    // Stream identifier.
    input  wire [31:0] sid_i,
    // Results.
    output wire        out_of_range_o,
    output wire [31:0] upper_index_o,
    output wire [31:0] leaf_index_o
);

    wire [31:0] size_mask;
    wire [31:0] split_mask;
    wire [31:0] sid_in_range;

    assign size_mask      = (eff_size_i >= 6'h20) ? 32'hFFFF_FFFF
                                                  : ~(32'hFFFF_FFFF << eff_size_i);
    assign split_mask     = ~(32'hFFFF_FFFF << eff_split_i);
    // Identifiers at or above two to the size are refused even if a descriptor spans more.
    assign out_of_range_o = (eff_size_i < 6'h20) && ((sid_i & ~size_mask) != 32'h0);
    assign sid_in_range   = sid_i & size_mask;
    // When the split reaches the size, the upper index is always zero: one descriptor.
    assign upper_index_o  = two_level_i ? (sid_in_range >> eff_split_i) : 32'h0;
    assign leaf_index_o   = two_level_i ? (sid_in_range & split_mask) : sid_in_range;

endmodule
`default_nettype wire

// File: design/sstc_secure_cfg.v
`timescale 1ns/1ps
`default_nettype none
`include "sstc_map.vh"

// Summary of operation
// - Format 01 two-level, everything else linear.
// - Format and split read zero without multilevel support.
// - Split counts leaf identifier bits: 6, 8, 10.
// - Reserved split encodings act as six.
// - Split ignored when format is linear.
// - High bits pick descriptor, low bits index leaf.
// - Identifiers at or above two-to-size stay unreachable.
// - Upper level holds max(1, 2^(size-split)) descriptors.
// - Size capped at identifier width, readback unchanged.
// - Out-of-range identifier aborts, logs if permitted.
// - Absent or non-secure access reads zero, ignores writes.
// - Writable only when unfixed, enable and acknowledge clear.
// - Fixed configuration loads chosen constants from the cycle after reset.
// - Unfixed configuration reset value is undefined.
// - Queue base holds address bits 51 to 5.
// - Queue base aligned to max(queue bytes, 32).
// - Bit 62 is the queue read-allocate hint.
// - Queue size uses capped at implemented maximum.
// - Linear table base aligned to table size.
// - Queue index width equals size, wrap above.
module sstc_secure_cfg
#(
    parameter [5:0] STREAM_ID_WIDTH   = 6'h10,
    parameter [4:0] MAX_CMDQ_SIZE     = 5'h13,
    parameter [5:0] OUT_ADDR_SIZE     = 6'h30
)
(
    // Clock and reset.
    input  wire        CORE_CLK_I,
    input  wire        RST_I,
    // Implementation straps from the same clock domain.
    input  wire        SECURE_STATE_PRESENT_I,
    input  wire        MULTILEVEL_TABLE_SUPPORT_I,
    input  wire        TABLE_CONFIG_FIXED_I,
    input  wire        QUEUE_CONFIG_FIXED_I,
    // Enables and acknowledges.
    input  wire        TRANSLATION_ENABLE_I,
    input  wire        TRANSLATION_ENABLE_ACK_I,
    input  wire        CMD_QUEUE_ENABLE_I,
    input  wire        CMD_QUEUE_ENABLE_ACK_I,
    input  wire        INVALID_STREAM_LOGGING_I,
    // Register access port, 32-bit words, single-cycle.
    input  wire        REG_SEL_I,
    input  wire        REG_WR_I,
    input  wire        REG_SECURE_I,
    input  wire [15:0] REG_ADDR_I,
    input  wire [31:0] REG_WDATA_I,
    input  wire [3:0]  REG_BE_I,
    output wire [31:0] REG_RDATA_O,
    output wire        REG_HIT_O,
    // Incoming transaction stream identifier.
    input  wire        SID_VALID_I,
    input  wire [31:0] SID_I,
    output reg         SID_ABORT_O,
    output reg         BAD_STREAM_ID_EVENT_O,
    output reg  [31:0] UPPER_INDEX_O,
    output reg  [31:0] LEAF_INDEX_O,
    // Effective configuration for the table and queue walkers.
    output reg         TWO_LEVEL_O,
    output reg  [5:0]  EFF_TABLE_SIZE_O,
    output reg  [4:0]  EFF_SPLIT_O,
    output reg  [5:0]  TABLE_BASE_ALIGN_LOG2_O,
    output reg  [63:0] CMDQ_BASE_ADDR_O,
    output reg  [4:0]  EFF_CMDQ_SIZE_O,
    output reg         CMDQ_READ_ALLOCATE_O,
    output reg  [4:0]  CMDQ_WRAP_BIT_O
);

    // Preset contents loaded while a configuration is fixed.
    localparam [31:0] cfg_preset  = `SSTC_RST_STRTAB_CFG;
    localparam [63:0] cmdq_preset = `SSTC_RST_CMDQ_BASE;

    // Stored register contents.
    reg  [1:0]  table_format_r;
    reg  [4:0]  split_r;
    reg  [5:0]  size_exponent_r;
    reg         read_allocate_hint_r;
    reg  [51:5] cmdq_addr_r;
    reg  [4:0]  cmdq_size_r;

    wire        access_ok;
    wire        hit_cfg;
    wire        hit_lo;
    wire        hit_hi;
    wire        cfg_writable;
    wire        cmdq_writable;
    wire [31:0] cfg_word;
    wire [63:0] cmdq_word;
    reg  [31:0] rdata;

    wire        fmt_two_level;
    wire [4:0]  split_eff;
    wire [5:0]  size_eff;
    wire [4:0]  qsize_eff;
    wire [51:0] oas_mask;
    wire [51:0] qalign_mask;
    wire [5:0]  qalign_log2;
    wire        chk_oor;
    wire [31:0] chk_upper;
    wire [31:0] chk_leaf;

    // Non-secure accesses and an absent secure state see nothing.
    assign access_ok = REG_SEL_I && REG_SECURE_I && SECURE_STATE_PRESENT_I;
    assign hit_cfg   = (REG_ADDR_I == `SSTC_OFF_STRTAB_CFG);
    assign hit_lo    = (REG_ADDR_I == `SSTC_OFF_CMDQ_BASE_LO);
    assign hit_hi    = (REG_ADDR_I == `SSTC_OFF_CMDQ_BASE_HI);
    assign REG_HIT_O = REG_SEL_I && (hit_cfg || hit_lo || hit_hi);

    assign cfg_writable  = !TABLE_CONFIG_FIXED_I && !TRANSLATION_ENABLE_I
                           && !TRANSLATION_ENABLE_ACK_I;
    assign cmdq_writable = !QUEUE_CONFIG_FIXED_I && !CMD_QUEUE_ENABLE_I
                           && !CMD_QUEUE_ENABLE_ACK_I;

    // Format and split fields vanish without multilevel support.
    assign cfg_word = {14'h0,
                       MULTILEVEL_TABLE_SUPPORT_I ? table_format_r : 2'h0,
                       5'h0,
                       MULTILEVEL_TABLE_SUPPORT_I ? split_r : 5'h0,
                       size_exponent_r};
    assign cmdq_word = {1'b0, read_allocate_hint_r, 10'h0, cmdq_addr_r, 5'h0};

    always @*
    begin
        rdata = 32'h0;
        if (access_ok && !REG_WR_I)
        begin
            if (hit_cfg)
            begin
                rdata = cfg_word;
            end
            else if (hit_lo)
            begin
                rdata = {cmdq_word[31:5], cmdq_size_r};
            end
            else if (hit_hi)
            begin
                rdata = cmdq_word[63:32];
            end
        end
    end
    assign REG_RDATA_O = rdata;

    // Reserved format encodings fall back to linear.
    assign fmt_two_level = MULTILEVEL_TABLE_SUPPORT_I
                           && (table_format_r == `SSTC_FMT_TWO_LEVEL);
    // Reserved splits act as six; a linear table ignores the split.
    assign split_eff = !fmt_two_level ? 5'h0 :
                       (split_r == `SSTC_SPLIT_8)  ? `SSTC_SPLIT_8 :
                       (split_r == `SSTC_SPLIT_10) ? `SSTC_SPLIT_10 :
                       `SSTC_SPLIT_6;
    assign size_eff  = (size_exponent_r > STREAM_ID_WIDTH) ? STREAM_ID_WIDTH
                                                           : size_exponent_r;
    assign qsize_eff = (cmdq_size_r > MAX_CMDQ_SIZE) ? MAX_CMDQ_SIZE : cmdq_size_r;

    // Queue of 2^n 16-byte entries needs 2^(n+4) alignment, never below 32 bytes.
    assign qalign_log2 = ({1'b0, qsize_eff} + 6'h04 > `SSTC_QMIN_ALIGN_LOG2)
                         ? ({1'b0, qsize_eff} + 6'h04) : `SSTC_QMIN_ALIGN_LOG2;
    assign qalign_mask = 52'hF_FFFF_FFFF_FFFF << qalign_log2;
    assign oas_mask    = (OUT_ADDR_SIZE >= 6'h34) ? 52'hF_FFFF_FFFF_FFFF
                         : ~(52'hF_FFFF_FFFF_FFFF << OUT_ADDR_SIZE);

    sstc_range_check u_range_check
    (
        .two_level_i    (fmt_two_level),
        .eff_size_i     (size_eff),
        .eff_split_i    (split_eff),
        .sid_i          (SID_I),
        .out_of_range_o (chk_oor),
        .upper_index_o  (chk_upper),
        .leaf_index_o   (chk_leaf)
    );

    // Stream table configuration register.
    always @(posedge CORE_CLK_I)
    begin
        if (RST_I)
        begin
            // Unfixed reset value is undefined; zero is one legal choice.
            table_format_r  <= `SSTC_FMT_LINEAR;
            split_r         <= 5'h0;
            size_exponent_r <= 6'h0;
        end
        else if (TABLE_CONFIG_FIXED_I)
        begin
            table_format_r  <= cfg_preset[`SSTC_FMT_HI:`SSTC_FMT_LO];
            split_r         <= cfg_preset[`SSTC_SPLIT_HI:`SSTC_SPLIT_LO];
            size_exponent_r <= cfg_preset[`SSTC_SIZE_HI:`SSTC_SIZE_LO];
        end
        else if (access_ok && REG_WR_I && hit_cfg && cfg_writable)
        begin
            if (REG_BE_I[0])
            begin
                size_exponent_r <= REG_WDATA_I[`SSTC_SIZE_HI:`SSTC_SIZE_LO];
                split_r[1:0]    <= REG_WDATA_I[7:6];
            end
            if (REG_BE_I[1])
            begin
                split_r[4:2] <= REG_WDATA_I[10:8];
            end
            if (REG_BE_I[2])
            begin
                table_format_r <= REG_WDATA_I[`SSTC_FMT_HI:`SSTC_FMT_LO];
            end
        end
    end

    // Command queue base register, low word then high word.
    always @(posedge CORE_CLK_I)
    begin
        if (RST_I)
        begin
            read_allocate_hint_r <= 1'b0;
            cmdq_addr_r          <= 47'h0;
            cmdq_size_r          <= 5'h0;
        end
        else if (QUEUE_CONFIG_FIXED_I)
        begin
            read_allocate_hint_r <= cmdq_preset[`SSTC_RA_BIT];
            cmdq_addr_r          <= cmdq_preset[`SSTC_ADDR_HI:`SSTC_ADDR_LO];
            cmdq_size_r          <= cmdq_preset[`SSTC_QSIZE_HI:`SSTC_QSIZE_LO];
        end
        else if (access_ok && REG_WR_I && cmdq_writable)
        begin
            if (hit_lo)
            begin
                if (REG_BE_I[0])
                begin
                    cmdq_size_r     <= REG_WDATA_I[`SSTC_QSIZE_HI:`SSTC_QSIZE_LO];
                    cmdq_addr_r[7:5] <= REG_WDATA_I[7:5];
                end
                if (REG_BE_I[1])
                begin
                    cmdq_addr_r[15:8] <= REG_WDATA_I[15:8];
                end
                if (REG_BE_I[2])
                begin
                    cmdq_addr_r[23:16] <= REG_WDATA_I[23:16];
                end
                if (REG_BE_I[3])
                begin
                    cmdq_addr_r[31:24] <= REG_WDATA_I[31:24];
                end
            end
            if (hit_hi)
            begin
                if (REG_BE_I[0])
                begin
                    cmdq_addr_r[39:32] <= REG_WDATA_I[7:0];
                end
                if (REG_BE_I[1])
                begin
                    cmdq_addr_r[47:40] <= REG_WDATA_I[15:8];
                end
                if (REG_BE_I[2])
                begin
                    cmdq_addr_r[51:48] <= REG_WDATA_I[19:16];
                end
                if (REG_BE_I[3])
                begin
                    read_allocate_hint_r <= REG_WDATA_I[30];
                end
            end
        end
    end

    // Effective configuration and stream identifier results, registered.
    always @(posedge CORE_CLK_I)
    begin
        if (RST_I)
        begin
            SID_ABORT_O             <= 1'b0;
            BAD_STREAM_ID_EVENT_O   <= 1'b0;
            UPPER_INDEX_O           <= 32'h0;
            LEAF_INDEX_O            <= 32'h0;
            TWO_LEVEL_O             <= 1'b0;
            EFF_TABLE_SIZE_O        <= 6'h0;
            EFF_SPLIT_O             <= 5'h0;
            TABLE_BASE_ALIGN_LOG2_O <= 6'h0;
            CMDQ_BASE_ADDR_O        <= 64'h0;
            EFF_CMDQ_SIZE_O         <= 5'h0;
            CMDQ_READ_ALLOCATE_O    <= 1'b0;
            CMDQ_WRAP_BIT_O         <= 5'h0;
        end
        else
        begin
            SID_ABORT_O           <= SID_VALID_I && chk_oor;
            BAD_STREAM_ID_EVENT_O <= SID_VALID_I && chk_oor && INVALID_STREAM_LOGGING_I;
            UPPER_INDEX_O         <= chk_upper;
            LEAF_INDEX_O          <= chk_leaf;
            TWO_LEVEL_O           <= fmt_two_level;
            EFF_TABLE_SIZE_O      <= size_eff;
            EFF_SPLIT_O           <= split_eff;
            // Linear base clears bits up to size plus five, from the literal size value.
            TABLE_BASE_ALIGN_LOG2_O <= fmt_two_level ? 6'h0 : size_exponent_r + 6'h06;
            CMDQ_BASE_ADDR_O      <= {12'h0, {cmdq_addr_r, 5'h0} & oas_mask & qalign_mask};
            EFF_CMDQ_SIZE_O       <= qsize_eff;
            CMDQ_READ_ALLOCATE_O  <= read_allocate_hint_r;
            CMDQ_WRAP_BIT_O       <= qsize_eff;
        end
    end

endmodule
`default_nettype wire

// File: dv/sstc_secure_cfg_props.sv
`timescale 1ns/1ps
`default_nettype none
module sstc_props
#(
    parameter [5:0] STREAM_ID_WIDTH = 6'h10,
    parameter [4:0] MAX_CMDQ_SIZE   = 5'h13,
    parameter [5:0] OUT_ADDR_SIZE   = 6'h30
)
(
    // Clock, reset and straps.
    input wire logic        CORE_CLK_I,
    input wire logic        RST_I,
    input wire logic        SECURE_STATE_PRESENT_I,
    input wire logic        INVALID_STREAM_LOGGING_I,
    // Register access.
    input wire logic        REG_SEL_I,
    input wire logic        REG_WR_I,
    input wire logic        REG_SECURE_I,
    input wire logic [31:0] REG_RDATA_O,
    // Stream identifier path.
    input wire logic        SID_VALID_I,
    input wire logic [31:0] SID_I,
    input wire logic        SID_ABORT_O,
    input wire logic        BAD_STREAM_ID_EVENT_O,
    input wire logic [31:0] UPPER_INDEX_O,
    input wire logic [31:0] LEAF_INDEX_O,
    // Effective configuration.
    input wire logic        TWO_LEVEL_O,
    input wire logic [5:0]  EFF_TABLE_SIZE_O,
    input wire logic [4:0]  EFF_SPLIT_O,
    input wire logic [63:0] CMDQ_BASE_ADDR_O,
    input wire logic [4:0]  EFF_CMDQ_SIZE_O,
    input wire logic [4:0]  CMDQ_WRAP_BIT_O
);
    // Queue base alignment is never finer than 32 bytes.
    wire [5:0]  q_al   = (EFF_CMDQ_SIZE_O + 6'h4 > 6'h5) ? EFF_CMDQ_SIZE_O + 6'h4 : 6'h5;
    wire [63:0] q_mask = (64'h1 << q_al) - 64'h1;

    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);

    chk_nonsec_read_zero: assert property (
        REG_SEL_I && !REG_WR_I && (!REG_SECURE_I || !SECURE_STATE_PRESENT_I)
        |-> REG_RDATA_O == 32'h0) else $error("non-secure read not zero");
    chk_sid_abort_range: assert property (
        $stable(EFF_TABLE_SIZE_O) |-> SID_ABORT_O ==
        ($past(SID_VALID_I) && |($past(SID_I) >> EFF_TABLE_SIZE_O)))
        else $error("abort does not match range");
    chk_event_gating: assert property (
        BAD_STREAM_ID_EVENT_O == (SID_ABORT_O && $past(INVALID_STREAM_LOGGING_I)))
        else $error("bad stream event gating wrong");
    chk_index_split: assert property (
        TWO_LEVEL_O && $stable(TWO_LEVEL_O) && $stable(EFF_SPLIT_O) && $stable(EFF_TABLE_SIZE_O)
        && ($past(SID_I) >> EFF_TABLE_SIZE_O) == 32'h0
        |-> LEAF_INDEX_O == ($past(SID_I) & ~(32'hFFFF_FFFF << EFF_SPLIT_O))
        && UPPER_INDEX_O == ($past(SID_I) >> EFF_SPLIT_O)) else $error("index split wrong");
    chk_split_legal: assert property (
        TWO_LEVEL_O |-> EFF_SPLIT_O inside {5'h06, 5'h08, 5'h0A})
        else $error("reserved split not treated as six");
    chk_size_capped: assert property (
        EFF_TABLE_SIZE_O <= STREAM_ID_WIDTH) else $error("table size not capped");
    chk_wrap_position: assert property (
        CMDQ_WRAP_BIT_O == EFF_CMDQ_SIZE_O && EFF_CMDQ_SIZE_O <= MAX_CMDQ_SIZE)
        else $error("queue size or wrap position wrong");
    chk_queue_base_align: assert property (
        (CMDQ_BASE_ADDR_O & q_mask) == 64'h0 && (CMDQ_BASE_ADDR_O >> OUT_ADDR_SIZE) == 64'h0)
        else $error("queue base not aligned");

    cov_abort_logged: cover property (SID_ABORT_O && BAD_STREAM_ID_EVENT_O);
    cov_split_ten: cover property (TWO_LEVEL_O && EFF_SPLIT_O == 5'h0A);
    cov_nonsec_access: cover property (REG_SEL_I && !REG_SECURE_I);
endmodule

bind sstc_secure_cfg sstc_props #(.STREAM_ID_WIDTH(STREAM_ID_WIDTH),
    .MAX_CMDQ_SIZE(MAX_CMDQ_SIZE), .OUT_ADDR_SIZE(OUT_ADDR_SIZE)) sstc_props_i (.*);
`default_nettype wire

// File: dv/sstc_secure_cfg_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sstc_map.vh"
module sstc_secure_cfg_tb;
    localparam logic [5:0] SIDW = 6'h10;
    localparam logic [4:0] QMAX = 5'h13;
    logic        CORE_CLK_I = 0, RST_I = 1, SECURE_STATE_PRESENT_I = 1;
    logic        MULTILEVEL_TABLE_SUPPORT_I = 1, TABLE_CONFIG_FIXED_I = 0;
    logic        QUEUE_CONFIG_FIXED_I = 0, TRANSLATION_ENABLE_I = 0;
    logic        TRANSLATION_ENABLE_ACK_I = 0, CMD_QUEUE_ENABLE_I = 0;
    logic        CMD_QUEUE_ENABLE_ACK_I = 0, INVALID_STREAM_LOGGING_I = 0;
    logic        REG_SEL_I = 0, REG_WR_I = 0, REG_SECURE_I = 0, SID_VALID_I = 0;
    logic [15:0] REG_ADDR_I = 0;
    logic [31:0] REG_WDATA_I = 0, SID_I = 0;
    logic [3:0]  REG_BE_I = 0;
    wire  [31:0] REG_RDATA_O, UPPER_INDEX_O, LEAF_INDEX_O;
    wire         REG_HIT_O, SID_ABORT_O, BAD_STREAM_ID_EVENT_O, TWO_LEVEL_O;
    wire         CMDQ_READ_ALLOCATE_O;
    wire  [5:0]  EFF_TABLE_SIZE_O, TABLE_BASE_ALIGN_LOG2_O;
    wire  [4:0]  EFF_SPLIT_O, EFF_CMDQ_SIZE_O, CMDQ_WRAP_BIT_O;
    wire  [63:0] CMDQ_BASE_ADDR_O;
    int          n_fail = 0, comparisons = 0;
    logic [31:0] cfg_s = 0, rd;
    logic [63:0] qb_s = 0;
    logic        hit;

    sstc_secure_cfg #(.STREAM_ID_WIDTH(SIDW), .MAX_CMDQ_SIZE(QMAX)) sstc_secure_cfg_i (.*);

    initial forever #4 CORE_CLK_I = ~CORE_CLK_I;

    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // One register access; the strobe stays up until the caller's next negedge.
    task automatic acc(input logic wr, input logic sec, input logic [15:0] a,
                       input logic [31:0] d, input logic [3:0] be, output logic [31:0] r);
        @(negedge CORE_CLK_I);
        {REG_SEL_I, REG_WR_I, REG_SECURE_I, REG_ADDR_I, REG_WDATA_I, REG_BE_I} =
            {1'b1, wr, sec, a, d, be};
        @(posedge CORE_CLK_I);
        r = REG_RDATA_O;
        hit = REG_HIT_O;
    endtask

    function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] be);
        for (int i = 0; i < 4; i++)
            if (be[i]) o[8*i+:8] = n[8*i+:8];
        return o;
    endfunction

    function automatic logic wok(input logic sec, input logic fx, input logic en,
                                 input logic ack);
        return sec && SECURE_STATE_PRESENT_I && !fx && !en && !ack;
    endfunction

    function automatic logic [63:0] qexp(input logic [63:0] q);
        logic [5:0] e;
        e = q[4:0] > QMAX ? QMAX : q[4:0];
        e = e + 6'h4 > 6'h5 ? e + 6'h4 : 6'h5;
        return q & 64'h0000_FFFF_FFFF_FFE0 & ~((64'h1 << e) - 64'h1);
    endfunction

    initial
    begin
        #400000;
        n_fail++;
        report_and_stop;
    end

    initial
    begin
        logic [4:0]  sp;
        logic [5:0]  sz, es;
        logic [31:0] d, s, ps;
        logic [3:0]  be;
        logic        sec, two, ok, pv, pl;
        d = $urandom(55);
        repeat (5) @(posedge CORE_CLK_I);
        @(negedge CORE_CLK_I);
        RST_I = 0;
        for (int r = 0; r < 60; r++)
        begin
            @(negedge CORE_CLK_I);
            {REG_SEL_I, SID_VALID_I} = 2'h0;
            if (r == 30)
            begin
                RST_I = 1;
                repeat (2) @(negedge CORE_CLK_I);
                RST_I = 0;
                {cfg_s, qb_s} = 96'h0;
            end
            SECURE_STATE_PRESENT_I = $urandom_range(0, 9) != 0;
            MULTILEVEL_TABLE_SUPPORT_I = 1'($urandom);
            TABLE_CONFIG_FIXED_I = $urandom_range(0, 3) == 0;
            QUEUE_CONFIG_FIXED_I = $urandom_range(0, 3) == 0;
            {TRANSLATION_ENABLE_I, TRANSLATION_ENABLE_ACK_I, CMD_QUEUE_ENABLE_I,
                CMD_QUEUE_ENABLE_ACK_I} = 4'($urandom) & {4{1'($urandom)}};
            if (TABLE_CONFIG_FIXED_I) cfg_s = `SSTC_RST_STRTAB_CFG;
            if (QUEUE_CONFIG_FIXED_I) qb_s = `SSTC_RST_CMDQ_BASE;
            sec = $urandom_range(0, 3) != 0;
            be = r % 3 ? 4'hF : 4'($urandom);
            d = $urandom;
            d[17:16] = 2'($urandom);
            d[10:6] = r % 2 ? 5'h6 + 5'(2 * $urandom_range(0, 2)) : 5'($urandom);
            d[5:0] = r == 2 ? 6'h14 : 6'($urandom_range(0, 40));
            if (d[17:16] == 2'h1 && d[10:6] > d[5:0]) d[17:16] = 2'h0;
            acc(1, sec, `SSTC_OFF_STRTAB_CFG, d, be, rd);
            if (wok(sec, TABLE_CONFIG_FIXED_I, TRANSLATION_ENABLE_I, TRANSLATION_ENABLE_ACK_I))
                cfg_s = mrg(cfg_s, d, be);
            for (int w = 0; w < 2; w++)
            begin
                d = $urandom;
                if (w == 0) d[4:0] = r < 2 ? 5'(r * 31) : 5'($urandom);
                acc(1, sec, w ? `SSTC_OFF_CMDQ_BASE_HI : `SSTC_OFF_CMDQ_BASE_LO, d, be, rd);
                if (wok(sec, QUEUE_CONFIG_FIXED_I, CMD_QUEUE_ENABLE_I, CMD_QUEUE_ENABLE_ACK_I))
                    qb_s[32*w+:32] = mrg(qb_s[32*w+:32], d, be);
            end
            sec = $urandom_range(0, 3) != 0;
            acc(0, sec, `SSTC_OFF_STRTAB_CFG, 0, 4'hF, rd);
            chk("cfg_read", rd, !(sec && SECURE_STATE_PRESENT_I) ? 32'h0 : cfg_s &
                (MULTILEVEL_TABLE_SUPPORT_I ? 32'h0003_07FF : 32'h0000_003F));
            chk("hit", hit, 1'b1);
            for (int w = 0; w < 2; w++)
            begin
                acc(0, sec, w ? `SSTC_OFF_CMDQ_BASE_HI : `SSTC_OFF_CMDQ_BASE_LO, 0, 4'hF, rd);
                chk("queue_read", rd, (sec && SECURE_STATE_PRESENT_I) ?
                    32'((qb_s & 64'h400F_FFFF_FFFF_FFFF) >> (32 * w)) : 32'h0);
            end
            acc(0, 1, 16'h808C, 0, 4'hF, rd);
            chk("unmapped", {rd, hit}, 33'h0);
            @(negedge CORE_CLK_I);
            REG_SEL_I = 0;
            CMD_QUEUE_ENABLE_I = 1;
            sp = cfg_s[10:6];
            sz = cfg_s[5:0];
            two = MULTILEVEL_TABLE_SUPPORT_I && cfg_s[17:16] == 2'h1;
            es = sz > SIDW ? SIDW : sz;
            if (!(sp inside {5'h06, 5'h08, 5'h0A})) sp = 5'h06;
            if (!SECURE_STATE_PRESENT_I) continue;
            chk("two_level", TWO_LEVEL_O, two);
            chk("table_size", EFF_TABLE_SIZE_O, es);
            chk("split", EFF_SPLIT_O, two ? sp : 5'h0);
            chk("base_align", TABLE_BASE_ALIGN_LOG2_O, two ? 6'h0 : sz + 6'h6);
            chk("queue_base", CMDQ_BASE_ADDR_O, qexp(qb_s));
            chk("queue_size", EFF_CMDQ_SIZE_O, qb_s[4:0] > QMAX ? QMAX : qb_s[4:0]);
            chk("read_alloc", CMDQ_READ_ALLOCATE_O, qb_s[62]);
            chk("wrap_bit", CMDQ_WRAP_BIT_O, qb_s[4:0] > QMAX ? QMAX : qb_s[4:0]);
            {ps, pv, pl} = {SID_I, 2'h0};
            repeat (10)
            begin
                @(negedge CORE_CLK_I);
                ok = pv && (ps >> es) != 32'h0;
                chk("abort", SID_ABORT_O, ok);
                chk("event", BAD_STREAM_ID_EVENT_O, ok && pl);
                if ((ps >> es) == 32'h0)
                    chk("index", {UPPER_INDEX_O, LEAF_INDEX_O}, two ?
                        {ps >> sp, ps & ~(32'hFFFF_FFFF << sp)} : {32'h0, ps});
                s = $urandom_range(0, 1) ? $urandom >> $urandom_range(0, 31) :
                    (32'h1 << es) + 32'($urandom_range(0, 2)) - 32'h1;
                SID_VALID_I = $urandom_range(0, 3) != 0;
                INVALID_STREAM_LOGGING_I = 1'($urandom);
                SID_I = s;
                {ps, pv, pl} = {s, SID_VALID_I, INVALID_STREAM_LOGGING_I};
            end
        end
        report_and_stop;
    end
endmodule
`default_nettype wire
